// File: sacs_top.sv
// conversion sequencer: prescaler, start paths, timing, selection lock
// assumes analog side samples on sh_pulse and returns a result on done
`timescale 1ns/1ps
module sacs_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trig_in,
   input wire logic sleep_quiet,
   input wire logic [9:0] result_in,
   output logic sh_pulse,
   output logic conv_active,
   output logic done_irq_req,
   output sacs_pkg::sacs_sel_t sel_active
);
   ////////////////////////////////////////////////////////////////////////
   logic enable_q, start_q, auto_q, done_q, done_ie_q, free_q, diff_q;
   logic [2:0] presc_sel_q;
   sacs_pkg::sacs_sel_t sel_tmp_q;
   logic [9:0] result_q;
   logic block_q, first_q;
   logic [6:0] presc_q;
   logic [2:0] trig_sync_q;
   logic trig_prev_q;
   logic [5:0] half_q, len2_q, sh2_q;
   logic [2:0] sleep_sync_q;
   logic sleep_prev_q;
   sacs_pkg::sacs_state_t state_q;
   logic aw_hold_q, w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic tick, half_tick, trig_edge, sleep_start, complete, sw_start;
   logic wr_go, wr_ctrl, wr_sel, rd_go;
   logic [7:0] raddr;
   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data accepted in either order
   assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign wr_ctrl = wr_go && awaddr_q == sacs_pkg::CTRL_OFF && wstrb_q[0];
   assign wr_sel = wr_go && awaddr_q == sacs_pkg::SEL_OFF && wstrb_q[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sacs_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_hold_q && !s_axi_awready;
         s_axi_wready <= !w_hold_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q <= sacs_pkg::STAT_OFF &&
               awaddr_q[1:0] == 2'b00) ? sacs_pkg::RESP_OKAY :
               sacs_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read path; reading the result bytes drives the update lock
   assign raddr = s_axi_araddr[7:0];
   assign rd_go = s_axi_arvalid && s_axi_arready;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= sacs_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= sacs_pkg::RESP_OKAY;
            unique case (raddr)
               sacs_pkg::CTRL_OFF: s_axi_rdata <= {22'h0, diff_q, free_q,
                  enable_q, start_q, auto_q, done_q, done_ie_q,
                  presc_sel_q};
               sacs_pkg::SEL_OFF: s_axi_rdata <= {25'h0, sel_tmp_q};
               sacs_pkg::RES_LO_OFF: s_axi_rdata <= {24'h0, result_q[7:0]};
               sacs_pkg::RES_HI_OFF: s_axi_rdata <= {30'h0, result_q[9:8]};
               sacs_pkg::STAT_OFF: s_axi_rdata <= {23'h0, sel_active,
                  conv_active, block_q};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= sacs_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // prescaler: free counter, taps give 2^n division for n of 1 to 7, selection 0 also divides by 2
   // a trigger restarts the count so trigger-to-sample delay is fixed
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable_q || trig_edge) begin
         presc_q <= sacs_pkg::PRESC_RST;
      end else begin
         presc_q <= presc_q + 7'h01;
      end
   end
   always_comb begin
      // half_tick marks each converter clock edge; tick only rising edge
      unique case (presc_sel_q)
         3'h0, 3'h1: half_tick = 1'b1;
         default: half_tick = (presc_q &
            ((7'h01 << (presc_sel_q - 3'h1)) - 7'h01)) ==
            ((7'h01 << (presc_sel_q - 3'h1)) - 7'h01);
      endcase
   end
   // rising converter edge: the divided clock bit is set on this count
   assign tick = half_tick && (presc_sel_q < 3'h2 ? presc_q[0] :
      presc_q[presc_sel_q - 3'h1]);
   ////////////////////////////////////////////////////////////////////////
   // trigger and sleep inputs come from outside: three stage synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_sync_q <= 3'h0;
         trig_prev_q <= 1'b0;
         sleep_sync_q <= 3'h0;
         sleep_prev_q <= 1'b0;
      end else begin
         trig_sync_q <= {trig_sync_q[1:0], trig_in};
         if (trig_sync_q[2] == trig_sync_q[1]) begin
            trig_prev_q <= trig_sync_q[2];
         end
         // sleep edge also waits for the second and third flops to agree
         sleep_sync_q <= {sleep_sync_q[1:0], sleep_quiet};
         if (sleep_sync_q[2] == sleep_sync_q[1]) begin
            sleep_prev_q <= sleep_sync_q[2];
         end
      end
   end
   // later edges during a conversion are dropped
   assign trig_edge = enable_q && auto_q && !free_q &&
      state_q == sacs_pkg::ST_IDLE && trig_sync_q[2] && trig_sync_q[1] &&
      !trig_prev_q;
   assign sleep_start = enable_q && !start_q && !auto_q && done_ie_q &&
      sleep_sync_q[2] && sleep_sync_q[1] && !sleep_prev_q &&
      state_q == sacs_pkg::ST_IDLE;
   // start is honoured only with enable in the same word, never when off
   assign sw_start = wr_ctrl && wdata_q[sacs_pkg::START_BIT] &&
      wdata_q[sacs_pkg::ENABLE_BIT];
   assign complete = state_q == sacs_pkg::ST_CONV && half_tick &&
      half_q == len2_q - 6'h01;
   ////////////////////////////////////////////////////////////////////////
   // control register and start bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q <= 1'b0;
         auto_q <= 1'b0;
         done_ie_q <= 1'b0;
         free_q <= 1'b0;
         diff_q <= 1'b0;
         presc_sel_q <= 3'h0;
         sel_tmp_q <= '0;
         start_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            enable_q <= wdata_q[sacs_pkg::ENABLE_BIT];
            auto_q <= wdata_q[sacs_pkg::AUTO_BIT];
            done_ie_q <= wdata_q[sacs_pkg::DONE_IE_BIT];
            presc_sel_q <= wdata_q[sacs_pkg::PRESC_LSB +: 3];
            free_q <= wdata_q[sacs_pkg::FREE_BIT];
            diff_q <= wdata_q[sacs_pkg::DIFF_BIT];
         end
         if (wr_sel) begin
            sel_tmp_q <= wdata_q[6:0];
         end
         // start bit: set by any start path, cleared on single completion
         if (sw_start || trig_edge || sleep_start) begin
            start_q <= 1'b1;
         end else if (complete && !(free_q && auto_q)) begin
            start_q <= 1'b0;
         end else if (wr_ctrl && !wdata_q[sacs_pkg::ENABLE_BIT]) begin
            start_q <= 1'b0;
         end
         // done flag: set wins over a write-one clear
         if (complete) begin
            done_q <= 1'b1;
         end else if (wr_ctrl && wdata_q[sacs_pkg::DONE_BIT]) begin
            done_q <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // sequencer: counts converter half clocks
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable_q) begin
         state_q <= sacs_pkg::ST_IDLE;
         half_q <= 6'h00;
         len2_q <= 6'h00;
         sh2_q <= 6'h00;
         first_q <= 1'b1;
         sh_pulse <= 1'b0;
         conv_active <= 1'b0;
      end else begin
         sh_pulse <= 1'b0;
         unique case (state_q)
            sacs_pkg::ST_IDLE: begin
               if (trig_edge) begin
                  state_q <= sacs_pkg::ST_CONV;
                  half_q <= 6'h00;
                  conv_active <= 1'b1;
                  len2_q <= (first_q || diff_q) ? sacs_pkg::FIRST_CYC << 1
                     : sacs_pkg::AUTO_CYC2;
                  sh2_q <= (first_q || diff_q) ? sacs_pkg::FIRST_SH2
                     : sacs_pkg::AUTO_SH2;
               end else if (start_q) begin
                  state_q <= sacs_pkg::ST_WAIT;
               end
            end
            sacs_pkg::ST_WAIT: begin
               if (tick) begin
                  state_q <= sacs_pkg::ST_CONV;
                  half_q <= 6'h00;
                  conv_active <= 1'b1;
                  len2_q <= first_q ? sacs_pkg::FIRST_CYC << 1
                     : sacs_pkg::NORM_CYC << 1;
                  sh2_q <= first_q ? sacs_pkg::FIRST_SH2 : sacs_pkg::NORM_SH2;
               end
            end
            sacs_pkg::ST_CONV: begin
               if (half_tick) begin
                  half_q <= half_q + 6'h01;
                  if (half_q == sh2_q - 6'h01) begin
                     sh_pulse <= 1'b1;
                  end
                  if (complete) begin
                     first_q <= 1'b0;
                     half_q <= 6'h00;
                     // free running: next conversion begins at once
                     if (free_q && auto_q) begin
                        len2_q <= sacs_pkg::NORM_CYC << 1;
                        sh2_q <= sacs_pkg::NORM_SH2;
                     end else begin
                        state_q <= sacs_pkg::ST_IDLE;
                        conv_active <= 1'b0;
                     end
                  end
               end
            end
            default: state_q <= sacs_pkg::ST_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // selection lock: follows temporary register when idle or in last cycle
   // len2_q - 2 marks the last two half clocks, the final converter cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_active <= '0;
      end else if (state_q != sacs_pkg::ST_CONV ||
                   half_q >= len2_q - 6'h02) begin
         sel_active <= sel_tmp_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // result store with read-order lock; irq request level
   // a result finishing between the two byte reads is lost by design
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_q <= 10'h000;
         block_q <= 1'b0;
         done_irq_req <= 1'b0;
      end else begin
         if (complete && !block_q) begin
            result_q <= result_in;
         end
         if (rd_go && raddr == sacs_pkg::RES_LO_OFF) begin
            block_q <= 1'b1;
         end else if (rd_go && raddr == sacs_pkg::RES_HI_OFF) begin
            block_q <= 1'b0;
         end
         done_irq_req <= done_q && done_ie_q;
      end
   end
endmodule // sacs_top

// File: sacs_pkg.sv
// package of constants and carrier types for the conversion sequencer
// assumes a 25 MHz cpu clock and an axi4-lite register port
package sacs_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] SEL_OFF = 8'h04;
   localparam logic [7:0] RES_LO_OFF = 8'h08;
   localparam logic [7:0] RES_HI_OFF = 8'h0C;
   localparam logic [7:0] STAT_OFF = 8'h10;
   // control field positions
   localparam int ENABLE_BIT = 7;
   localparam int START_BIT = 6;
   localparam int AUTO_BIT = 5;
   localparam int DONE_BIT = 4;
   localparam int DONE_IE_BIT = 3;
   localparam int PRESC_LSB = 0;
   localparam int FREE_BIT = 8;
   localparam int DIFF_BIT = 9;
   // conversion timing in converter clocks (half cycles for sampling and the auto length)
   localparam logic [5:0] NORM_CYC = 6'h0D;
   localparam logic [5:0] FIRST_CYC = 6'h19;
   localparam logic [5:0] AUTO_CYC2 = 6'h1B;
   localparam logic [5:0] NORM_SH2 = 6'h03;
   localparam logic [5:0] FIRST_SH2 = 6'h1B;
   localparam logic [5:0] AUTO_SH2 = 6'h04;
   localparam int TRIG_SYNC = 3;
   localparam logic [6:0] PRESC_RST = 7'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic [1:0] ref_sel;
      logic [4:0] chan_sel;
   } sacs_sel_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_CONV = 2'b10
   } sacs_state_t;
endpackage

// File: sacs_top_properties.sv
// checker of the sequencer port timing and the axi4-lite answers
// assumes binding onto sacs_top, one aclk domain, low prescale ratios
`timescale 1ns/1ps
module sacs_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sh_pulse,
   input wire logic conv_active,
   input wire sacs_pkg::sacs_sel_t sel_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   sequence conv_start;
      $rose(conv_active);
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   sh_one_cycle_a: assert property (
      sh_pulse |=> !sh_pulse) else $error("sample pulse too long");
   sh_in_conv_a: assert property (
      sh_pulse |-> conv_active) else $error("sample outside conversion");
   // bound holds for prescale ratios up to 64 only
   conv_sample_a: assert property (
      conv_start |-> ##[1:1000] sh_pulse) else $error("no sample");
   sel_lock_a: assert property (
      conv_start |=> $stable(sel_active) [*2])
      else $error("selection moved after start");
   rd_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (
      wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   bvalid_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   rvalid_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
endmodule // sacs_checker

bind sacs_top sacs_checker chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .sh_pulse(sh_pulse),
   .conv_active(conv_active), .sel_active(sel_active));

// File: sacs_analog_model.sv
// model of the analog mux and comparator array behind the sequencer
// assumes the result is taken in the completion cycle of a conversion
`timescale 1ns/1ps
module sacs_analog_model (
   input wire logic aclk,
   input wire logic sh_pulse,
   input wire logic conv_active,
   input wire sacs_pkg::sacs_sel_t sel_active,
   output logic [9:0] result_in
);
   logic idle_q = 1'b1;
   initial result_in = 10'h155;
   // code is held from sampling to completion, then churns while idle
   always @(posedge aclk) begin
      idle_q <= !conv_active;
      if (sh_pulse)
         result_in <= {sel_active, 3'h5};
      else if (idle_q && !conv_active)
         result_in <= ~result_in;
   end
endmodule // sacs_analog_model

// File: tb.sv
// self-checking bench for the conversion sequencer over axi4-lite
// assumes the analog model as far side and the 25 MHz aclk
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] CTL = sacs_pkg::CTRL_OFF;
   localparam logic [7:0] SEL = sacs_pkg::SEL_OFF;
   localparam logic [7:0] RLO = sacs_pkg::RES_LO_OFF;
   localparam logic [7:0] RHI = sacs_pkg::RES_HI_OFF;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd_q;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic trig_in = 0, sleep_quiet = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic sh_pulse, conv_active, done_irq_req;
   logic [1:0] bresp, rresp, resp_q;
   logic [9:0] result_in;
   sacs_pkg::sacs_sel_t sel_active;
   int failures = 0, n_tests = 0, cnt = 0, last_len = 0, sh_at = 0;
   int sh_n = 0, base;
   always #20 aclk = ~aclk;
   sacs_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_in(trig_in),
      .sleep_quiet(sleep_quiet), .result_in(result_in),
      .sh_pulse(sh_pulse), .conv_active(conv_active),
      .done_irq_req(done_irq_req), .sel_active(sel_active));
   sacs_analog_model model_u (.aclk(aclk), .sh_pulse(sh_pulse),
      .conv_active(conv_active), .sel_active(sel_active),
      .result_in(result_in));
   ////////////////////////////////////////////////////////////////////////
   // length and sample offset of each conversion, in aclk cycles
   always @(posedge aclk) begin
      if (sh_pulse) sh_n <= sh_n + 1;
      if (conv_active) begin
         cnt <= cnt + 1;
         if (sh_pulse) sh_at <= cnt;
      end else if (cnt != 0) begin
         last_len <= cnt;
         cnt <= 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("compares %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang(input int i);
      if (i >= 3000) begin
         failures++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 3000; i++) begin
         @(posedge aclk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
         if (bvalid) break;
      end
      hang(i);
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 3000; i++) begin
         @(posedge aclk);
         if (arready && arvalid) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd_q = rdata;
      resp_q = rresp;
      // bready and rready stay high between calls
      hang(i);
   endtask
   task automatic wait_lvl(input logic v);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge aclk);
         if (conv_active === v) break;
      end
      hang(i);
      @(posedge aclk);
   endtask
   task automatic conv();
      wait_lvl(1'b1);
      wait_lvl(1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(CTL);
      chk(rd_q, 32'h0);
      rd(8'h14);
      chk({rd_q[31:2], resp_q}, {30'h0, sacs_pkg::RESP_SLVERR});
      $display("test reset done");
      wr(SEL, 32'h23);
      wr(CTL, 32'h81);
      wr(CTL, 32'hC9);
      rd(CTL);
      chk(32'(rd_q[6]), 32'h1);
      conv();
      chk(32'(last_len), 32'(sacs_pkg::FIRST_CYC) * 2);
      chk(32'(sh_at), 32'(sacs_pkg::FIRST_SH2));
      rd(CTL);
      chk(32'(rd_q[6:4]), 32'h1);
      chk(32'(done_irq_req), 32'h1);
      rd(RLO);
      chk(32'(rd_q[7:0]), 32'h1D);
      rd(RHI);
      chk(32'(rd_q[1:0]), 32'h1);
      $display("test first conversion done");
      wr(CTL, 32'hDA);
      repeat (8) @(posedge aclk);
      wr(SEL, 32'h45);
      chk(32'(sel_active), 32'h23);
      wait_lvl(1'b0);
      chk(32'(last_len), 32'(sacs_pkg::NORM_CYC) * 4);
      chk(32'(sh_at), 32'(sacs_pkg::NORM_SH2) * 2);
      chk(32'(sel_active), 32'h45);
      rd(RLO);
      chk(32'(rd_q[7:0]), 32'h1D);
      wr(CTL, 32'hDA);
      conv();
      rd(CTL);
      chk(32'(rd_q[4]), 32'h1);
      rd(RHI);
      chk(32'(rd_q[1:0]), 32'h1);
      $display("test lock and blocking done");
      wr(CTL, 32'hB2);
      trig_in <= 1'b1;
      wait_lvl(1'b1);
      trig_in <= 1'b0;
      repeat (10) @(posedge aclk);
      trig_in <= 1'b1;
      wait_lvl(1'b0);
      chk(32'(last_len), 32'(sacs_pkg::AUTO_CYC2) * 2);
      chk(32'(sh_at), 32'(sacs_pkg::AUTO_SH2) * 2);
      repeat (100) @(posedge aclk);
      chk(32'(conv_active), 32'h0);
      $display("test auto trigger done");
      trig_in <= 1'b0;
      wr(CTL, 32'h2B2);
      repeat (4) @(posedge aclk);
      trig_in <= 1'b1;
      conv();
      chk(32'(last_len), 32'(sacs_pkg::FIRST_CYC) * 4);
      chk(32'(sh_at), 32'(sacs_pkg::FIRST_SH2) * 2);
      $display("test differential auto done");
      trig_in <= 1'b0;
      wr(CTL, 32'h99);
      sleep_quiet <= 1'b1;
      wait_lvl(1'b1);
      sleep_quiet <= 1'b0;
      wait_lvl(1'b0);
      chk(32'(done_irq_req), 32'h1);
      $display("test sleep start done");
      wr(CTL, 32'h1F1);
      base = sh_n;
      repeat (200) @(posedge aclk);
      chk(32'(sh_n - base >= 3), 32'h1);
      rd(CTL);
      chk(32'(rd_q[6]), 32'h1);
      wr(CTL, 32'h0);
      $display("test free running done");
      end_sim();
   end
endmodule // tb
